// ### rtl/adcst_seq.sv
// adcst_seq.sv - converter result hand-off and self-test sequencer
// assumes: apb master in the clk domain, fixture pins synchronous to clk,
// a comparator input that answers for the current approximation value
`timescale 1ns/1ps
`include "adcst_params.svh"

// Notes on behaviour
// - conversion end copies approximation to result
// - conversion end sets completion flag
// - sample window open first five cycles
// - low interrupt pin at reset enters loader
// - first load after reset clears counter bit1, each load steps bit0 fall
// - loader stores port a bytes until 0x80
// - three loads with calibration, two without, each routine but linearity run then reloaded
// - calibration only when c4, c5 low
// - c4 high holds dac ff0, c5 ends
// - full-scale adjust steps dac to fe8
// - port c low nibble lowers reference
// - increment and convert until result ff
// - linearity: clear, ramp 256 centre checks
// - all steps good drives pass low
// - first bad step halts, drives fail low
// - completion flag is control bit 7
// - converter runs continuously, 30 cycles each
module adcst_seq #(
    parameter int SAMPLE_CYCLES = `ADCST_SAMPLE_CYCLES,
    parameter int CONV_CYCLES = `ADCST_CONV_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic irq_pin,
    input wire logic [7:0] port_a_in,
    input wire logic [5:4] port_c_sw,
    output logic [3:0] port_c_ref,
    input wire logic cmp_above,
    output logic [7:0] approx_out,
    output logic sample_open,
    output adcst_pkg::adcst_fix_t fix,
    output logic [1:0] load_index
);
    import adcst_pkg::*;

    // ------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------
    initial begin
        if (SAMPLE_CYCLES < 1 || CONV_CYCLES < SAMPLE_CYCLES + 9)
            $error("adcst_seq: conversion too short for sample plus eight bits");
    end

    // ------------------------------------------------------------
    // shared helpers
    // ------------------------------------------------------------
    function automatic logic apb_hit(input logic [11:0] a, input logic [11:0] ofs);
        apb_hit = (a == ofs);
    endfunction : apb_hit

    adcst_state_t state_reg;
    logic [4:0] conv_cnt_reg;
    logic [7:0] approx_reg;
    logic [7:0] result_reg;
    logic [2:0] chan_reg;
    logic done_reg;
    logic conv_end;
    logic restart;
    logic [7:0] ram_ptr_reg;
    logic [7:0] ram_mem [0:127];
    logic [1:0] load_reg;
    logic [1:0] phase_reg;
    logic cal_en_reg;
    logic boot_sel_reg;
    logic first_reg;
    logic [11:0] dac_code_reg;
    logic [8:0] step_cnt_reg;
    logic [7:0] expect_reg;
    logic dac_tick_reg;
    logic [11:0] dac_target_reg;
    logic skip_reg;
    logic wr_ok;

    // apb access taken at the end of a one-cycle access phase
    assign wr_ok = psel & penable & pwrite;
    // control write restarts conversion
    assign restart = wr_ok & apb_hit(paddr, `ADCST_OFS_CTRL);
    assign conv_end = (conv_cnt_reg == 5'(CONV_CYCLES - 1)) & ~restart;

    // ------------------------------------------------------------
    // converter timing and successive approximation
    // ------------------------------------------------------------
    // free-running conversion cycle counter
    always_ff @(posedge clk) begin
        if (rst || restart || conv_end)
            conv_cnt_reg <= 5'h00;
        else
            conv_cnt_reg <= conv_cnt_reg + 5'h01;
    end

    // sample window over the first cycles
    always_ff @(posedge clk) begin
        if (rst)
            sample_open <= 1'b1;
        else if (restart || conv_end)
            sample_open <= 1'b1;
        else
            sample_open <= (conv_cnt_reg + 5'h01) < 5'(SAMPLE_CYCLES);
    end

    // binary search, one bit per cycle after the window
    always_ff @(posedge clk) begin
        if (rst || restart || conv_end) begin
            approx_reg <= `ADCST_APPROX_START;
        end else if (conv_cnt_reg >= 5'(SAMPLE_CYCLES)
                     && conv_cnt_reg < 5'(SAMPLE_CYCLES + 8)) begin
            for (int b = 0; b < 8; b++) begin
                if (conv_cnt_reg == 5'(SAMPLE_CYCLES + 7 - b))
                    approx_reg[b] <= cmp_above;
            end
            // next bit down for trial, none below bit 0
            for (int b = 1; b < 8; b++) begin
                if (conv_cnt_reg == 5'(SAMPLE_CYCLES + 7 - b))
                    approx_reg[b - 1] <= 1'b1;
            end
        end
    end
    assign approx_out = approx_reg;

    // result hand-off and completion flag, clear beats set
    always_ff @(posedge clk) begin
        if (rst) begin
            result_reg <= 8'h00;
            done_reg <= 1'b0;
        end else if (conv_end) begin
            result_reg <= approx_reg;
            done_reg <= 1'b1;
        end else if (restart) begin
            done_reg <= 1'b0;
        end
    end

    // channel select kept in the low control bits
    always_ff @(posedge clk) begin
        if (rst)
            chan_reg <= 3'h0;
        else if (restart)
            chan_reg <= pwdata[2:0];
    end

    // ------------------------------------------------------------
    // apb slave: zero wait, unmapped reads zero with error
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (psel && !penable) begin
                if (apb_hit(paddr, `ADCST_OFS_CTRL))
                    prdata <= {24'h000000, done_reg, 4'h0, chan_reg};
                else if (apb_hit(paddr, `ADCST_OFS_RESULT))
                    prdata <= {24'h000000, result_reg};
                else if (apb_hit(paddr, `ADCST_OFS_STATUS))
                    prdata <= {16'h0000, 2'b00, load_reg, state_reg, ram_ptr_reg};
                else if (apb_hit(paddr, `ADCST_OFS_BOOTDATA))
                    prdata <= {24'h000000, ram_mem[ram_ptr_reg[6:0] - 7'h01]}; // last byte
                else if (apb_hit(paddr, `ADCST_OFS_CMD))
                    prdata <= 32'h0000_0000;
                else
                    pslverr <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // boot selection captured after reset release
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            first_reg <= 1'b1;
            boot_sel_reg <= 1'b0;
            cal_en_reg <= 1'b0;
        end else if (first_reg) begin
            first_reg <= 1'b0;
            boot_sel_reg <= ~irq_pin;
            cal_en_reg <= ~port_c_sw[4] & ~port_c_sw[5];
        end
    end

    // ------------------------------------------------------------
    // loaded program store
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (state_reg == ADCST_LOAD && phase_reg == 2'd2)
            ram_mem[ram_ptr_reg[6:0]] <= port_a_in;
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= ADCST_IDLE;
            load_reg <= 2'd0;
            phase_reg <= 2'd0;
            ram_ptr_reg <= 8'h00;
            dac_code_reg <= 12'h000;
            step_cnt_reg <= 9'h000;
            expect_reg <= 8'h00;
            dac_tick_reg <= 1'b0;
            dac_target_reg <= 12'h000;
            skip_reg <= 1'b0;
            port_c_ref <= 4'h0;
            fix <= '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
        end else begin
            fix.dac_clr <= 1'b0;
            fix.dac_step <= 1'b0;
            fix.addr_clr <= 1'b0;
            case (state_reg)
                ADCST_IDLE: begin
                    if (!first_reg) begin
                        state_reg <= boot_sel_reg ? ADCST_LOAD : ADCST_USER;
                        fix.addr_clr <= boot_sel_reg;
                        load_reg <= cal_en_reg ? 2'd0 : 2'd1;
                        ram_ptr_reg <= 8'h00;
                        phase_reg <= 2'd0;
                    end
                end
                ADCST_USER: begin
                    state_reg <= ADCST_USER;
                end
                ADCST_LOAD: begin
                    // phase 0 settle, 2 store, 3 advance counter on fall
                    phase_reg <= phase_reg + 2'd1;
                    if (phase_reg == 2'd1)
                        fix.addr_step <= 1'b1;
                    if (phase_reg == 2'd3) begin
                        fix.addr_step <= 1'b0;
                        ram_ptr_reg <= ram_ptr_reg + 8'h01;
                        if (ram_ptr_reg + 8'h01 == `ADCST_LOAD_END) begin
                            ram_ptr_reg <= 8'h00;
                            fix.dac_clr <= 1'b1;
                            dac_code_reg <= 12'h000;
                            case (load_reg)
                                2'd0: state_reg <= ADCST_CAL;
                                2'd1: state_reg <= ADCST_FS_RAMP;
                                default: state_reg <= ADCST_LIN_CLR;
                            endcase
                        end
                    end
                end
                ADCST_CAL: begin
                    if (port_c_sw[5]) begin
                        state_reg <= ADCST_LOAD;
                        load_reg <= 2'd1;
                        fix.addr_clr <= 1'b0;
                    end else if (port_c_sw[4] && dac_code_reg != `ADCST_DAC_CAL_CODE) begin
                        dac_tick_reg <= ~dac_tick_reg;
                        if (dac_tick_reg) begin
                            fix.dac_step <= 1'b1;
                            dac_code_reg <= dac_code_reg + 12'h001;
                        end
                    end
                end
                ADCST_FS_RAMP: begin
                    dac_tick_reg <= ~dac_tick_reg;
                    if (dac_code_reg == `ADCST_DAC_FS_CODE) begin
                        state_reg <= ADCST_FS_ADJ;
                        port_c_ref <= 4'h0;
                    end else if (dac_tick_reg) begin
                        fix.dac_step <= 1'b1;
                        dac_code_reg <= dac_code_reg + 12'h001;
                    end
                end
                ADCST_FS_ADJ: begin
                    if (done_reg && conv_end == 1'b0 && conv_cnt_reg == 5'h00) begin
                        if (result_reg == `ADCST_FULL_CODE) begin
                            state_reg <= ADCST_LOAD;
                            load_reg <= 2'd2;
                        end else begin
                            port_c_ref <= port_c_ref + 4'h1;
                        end
                    end
                end
                ADCST_LIN_CLR: begin
                    step_cnt_reg <= 9'h000;
                    expect_reg <= 8'h00;
                    dac_target_reg <= 12'h000;
                    skip_reg <= 1'b1;
                    state_reg <= ADCST_LIN_WAIT;
                end
                ADCST_LIN_STEP: begin
                    dac_tick_reg <= ~dac_tick_reg;
                    if (dac_code_reg == dac_target_reg) begin
                        skip_reg <= 1'b1;
                        state_reg <= ADCST_LIN_WAIT;
                    end else if (dac_tick_reg) begin
                        fix.dac_step <= 1'b1;
                        dac_code_reg <= dac_code_reg + 12'h001;
                    end
                end
                ADCST_LIN_WAIT: begin
                    // conversion running on arrival holds an old sample
                    if (conv_end && skip_reg) begin
                        skip_reg <= 1'b0;
                    end else if (conv_end) begin
                        if (approx_reg != expect_reg) begin
                            state_reg <= ADCST_FAIL;
                            fix.fail_n <= 1'b0;
                        end else if (step_cnt_reg == `ADCST_RAMP_STEPS - 9'h001) begin
                            state_reg <= ADCST_PASS;
                            fix.pass_n <= 1'b0;
                        end else begin
                            step_cnt_reg <= step_cnt_reg + 9'h001;
                            expect_reg <= expect_reg + 8'h01;
                            dac_target_reg <= dac_target_reg + `ADCST_DAC_STEP;
                            state_reg <= ADCST_LIN_STEP;
                        end
                    end
                end
                ADCST_PASS: state_reg <= ADCST_PASS;
                ADCST_FAIL: state_reg <= ADCST_FAIL;
                default: state_reg <= ADCST_IDLE;
            endcase
        end
    end
    assign load_index = load_reg;

endmodule : adcst_seq

// ### rtl/adcst_params.svh
// adcst_params.svh - offsets, field positions, reset values and timing counts
// assumes: included by bare name wherever offsets or counts are needed
`ifndef ADCST_PARAMS_SVH
`define ADCST_PARAMS_SVH

// ------------------------------------------------------------
// register offsets (byte addresses on apb)
// ------------------------------------------------------------
`define ADCST_OFS_CTRL 12'h000
`define ADCST_OFS_RESULT 12'h004
`define ADCST_OFS_STATUS 12'h008
`define ADCST_OFS_CMD 12'h00c
`define ADCST_OFS_BOOTDATA 12'h010

// ------------------------------------------------------------
// field positions and values
// ------------------------------------------------------------
`define ADCST_CTRL_DONE_BIT 7
`define ADCST_APPROX_START 8'h80
`define ADCST_LOAD_END 8'h80
`define ADCST_DAC_CAL_CODE 12'hff0
`define ADCST_DAC_FS_CODE 12'hfe8
`define ADCST_DAC_STEP 12'h010
`define ADCST_FULL_CODE 8'hff
`define ADCST_RAMP_STEPS 9'h100
`define ADCST_PORTB_RESET 8'hff

// ------------------------------------------------------------
// timing, in machine cycles of the 100 ns clock
// ------------------------------------------------------------
`define ADCST_SAMPLE_CYCLES 5
`define ADCST_CONV_CYCLES 30

`endif

// ### rtl/adcst_pkg.sv
// adcst_pkg.sv - types shared by the self-test sequencer
// assumes: adcst_params.svh holds the numbers
package adcst_pkg;

    // ------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ADCST_IDLE = 4'b0000,
        ADCST_USER = 4'b0001,
        ADCST_LOAD = 4'b0010,
        ADCST_CAL = 4'b0011,
        ADCST_FS_RAMP = 4'b0100,
        ADCST_FS_ADJ = 4'b0101,
        ADCST_LIN_CLR = 4'b0110,
        ADCST_LIN_STEP = 4'b0111,
        ADCST_LIN_WAIT = 4'b1000,
        ADCST_PASS = 4'b1001,
        ADCST_FAIL = 4'b1010
    } adcst_state_t;

    // ------------------------------------------------------------
    // fixture port group
    // ------------------------------------------------------------
    typedef struct packed {
        logic addr_clr;   // port b bit 1, clears eprom address counter
        logic addr_step;  // port b bit 0, falling edge advances it
        logic dac_clr;    // clears the dac counter
        logic dac_step;   // rising edge advances the dac counter
        logic pass_n;     // port b bit 2, low = pass
        logic fail_n;     // port b bit 3, low = fail
    } adcst_fix_t;

endpackage : adcst_pkg

// ### testbench/adcst_seq_assertions.sv
// adcst_seq_assertions.sv - port-level checker for the self-test sequencer
// assumes: bound to adcst_seq, one clk domain, synchronous active-high rst
`timescale 1ns/1ps
`include "adcst_params.svh"
module adcst_seq_checker #(
    parameter int SAMPLE_CYCLES = 5,
    parameter int CONV_CYCLES = 30
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq_pin,
    input wire logic [3:0] port_c_ref,
    input wire logic sample_open,
    input wire adcst_pkg::adcst_fix_t fix,
    input wire logic [1:0] load_index
);
    import adcst_pkg::*;
    logic rst_d, so_d, user_boot, cnt_ok, wr_seen;
    int hi_cnt, per_cnt;
    wire ctrl_wr = psel && penable && pwrite && paddr == `ADCST_OFS_CTRL;
    wire rise = sample_open && !so_d;
    wire bad_addr = !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00c, 12'h010});

    // ------------------------------------------------------------
    // helper state
    // ------------------------------------------------------------
    // strap capture and window length
    always_ff @(posedge clk) begin
        rst_d <= rst;
        so_d <= sample_open;
        hi_cnt <= (rst || !sample_open) ? 0 : hi_cnt + 1;
        if (rst)
            user_boot <= 1'b0;
        else if (rst_d)
            user_boot <= irq_pin;
    end
    // conversion period, restarts by software marked
    always_ff @(posedge clk) begin
        if (rst) begin
            per_cnt <= 0;
            cnt_ok <= 1'b0;
            wr_seen <= 1'b0;
        end else if (rise) begin
            per_cnt <= 1;
            cnt_ok <= 1'b1;
            wr_seen <= ctrl_wr;
        end else begin
            per_cnt <= per_cnt + 1;
            wr_seen <= wr_seen || ctrl_wr;
        end
    end

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_win_end;
        sample_open ##1 !sample_open;
    endsequence
    AST_SETUP_READY: assert property (s_setup |=> pready)
        else $error("no ready after setup");
    AST_UNMAPPED_ERR: assert property (pready |-> pslverr == bad_addr)
        else $error("slave error does not match address");
    AST_SAMPLE_LEN: assert property (s_win_end ##0 !wr_seen |-> hi_cnt == SAMPLE_CYCLES)
        else $error("sample window length wrong");
    AST_CONV_PERIOD: assert property (rise && cnt_ok && !wr_seen && !ctrl_wr |->
        per_cnt == CONV_CYCLES)
        else $error("conversion period wrong");
    AST_USER_IDLE: assert property (user_boot |-> !fix.addr_clr && fix.addr_step)
        else $error("loader active in user boot");
    AST_CLR_PULSE: assert property (fix.addr_clr |=> !fix.addr_clr)
        else $error("address clear not a pulse");
    AST_REF_STEP: assert property ($changed(port_c_ref) |->
        load_index == 2'd1 && port_c_ref == $past(port_c_ref) + 4'h1)
        else $error("reference select step wrong");
    AST_LOAD_ORDER: assert property ($changed(load_index) |->
        load_index == $past(load_index) + 2'd1 && load_index != 2'd3)
        else $error("routine order wrong");
    AST_PASS_GOOD: assert property ($fell(fix.pass_n) |-> load_index == 2'd2 && fix.fail_n)
        else $error("pass outside linearity");
    AST_FAIL_HALT: assert property ($fell(fix.fail_n) |-> fix.pass_n ##2 ($stable(fix))[*8])
        else $error("activity after failure");
endmodule : adcst_seq_checker

bind adcst_seq adcst_seq_checker #(.SAMPLE_CYCLES(SAMPLE_CYCLES), .CONV_CYCLES(CONV_CYCLES)) u_chk (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pready(pready), .pslverr(pslverr), .irq_pin(irq_pin), .port_c_ref(port_c_ref),
    .sample_open(sample_open), .fix(fix), .load_index(load_index)
);

// ### testbench/adcst_fixture.sv
// adcst_fixture.sv - behavioural fixture: address counter, eprom, dac counter, reference
// assumes: fix pins registered on clk, comparator answers for approx_out at once
`timescale 1ns/1ps
module adcst_fixture (
    input wire logic clk,
    input wire adcst_pkg::adcst_fix_t fix,
    input wire logic sample_open,
    input wire logic [7:0] approx_out,
    input wire logic [3:0] port_c_ref,
    input wire logic [12:0] extra_mv,
    input wire logic [11:0] bad_dac,
    output logic [7:0] port_a_in,
    output logic cmp_above,
    output logic [11:0] dac_code
);
    import adcst_pkg::*;
    logic [11:0] addr_cnt = 12'h000;
    logic step_d = 1'b1;
    logic dstep_d = 1'b0;
    int vin_mv, vref_mv;
    int held_mv = 0;

    // ------------------------------------------------------------
    // counters
    // ------------------------------------------------------------
    initial dac_code = 12'h000;
    // eprom address, falling step edge advances
    always @(posedge clk) begin
        step_d <= fix.addr_step;
        if (fix.addr_clr)
            addr_cnt <= 12'h000;
        else if (step_d && !fix.addr_step)
            addr_cnt <= addr_cnt + 12'h001;
    end
    // second counter feeds the test dac code
    always @(posedge clk) begin
        dstep_d <= fix.dac_step;
        if (fix.dac_clr)
            dac_code <= 12'h000;
        else if (fix.dac_step && !dstep_d)
            dac_code <= dac_code + 12'h001;
    end
    // analog side in millivolts, bad_dac code reads 40 mv high
    assign port_a_in = addr_cnt[7:0] ^ 8'h3c;
    assign vin_mv = int'(dac_code) * 5 / 4 + int'(extra_mv) + ((dac_code == bad_dac) ? 40 : 0);
    assign vref_mv = 5160 - 10 * int'(port_c_ref);
    always @(posedge clk)
        if (sample_open)
            held_mv <= vin_mv;
    assign cmp_above = held_mv * 512 >= (2 * int'(approx_out) - 1) * vref_mv;
endmodule : adcst_fixture

// ### testbench/adc_self_test_sequencer_tb.sv
// adc_self_test_sequencer_tb.sv - self-checking bench for the self-test sequencer
// assumes: adcst_fixture on the far side, checker bound to adcst_seq
`timescale 1ns/1ps
`include "adcst_params.svh"
module adc_self_test_sequencer_tb;
    import adcst_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic irq_pin = 1'b1;
    logic [5:4] port_c_sw = 2'b11;
    logic [12:0] extra_mv = 13'h0000;
    logic [11:0] bad_dac = 12'hfff;
    logic saw_cal = 1'b0;
    logic [31:0] prdata, q;
    logic pready, pslverr, cmp_above, sample_open, e;
    logic [7:0] port_a_in, approx_out, exp_v;
    logic [3:0] port_c_ref;
    logic [11:0] dac_code;
    logic [1:0] load_index;
    adcst_fix_t fix;
    int fails = 0;
    int n_tests = 0;
    int seed = int'(32'hd248e63b);
    int i;

    always #50 clk = ~clk;

    adcst_seq u_dut (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq_pin(irq_pin), .port_a_in(port_a_in), .port_c_sw(port_c_sw),
        .port_c_ref(port_c_ref), .cmp_above(cmp_above), .approx_out(approx_out),
        .sample_open(sample_open), .fix(fix), .load_index(load_index)
    );
    adcst_fixture u_fix (
        .clk(clk), .fix(fix), .sample_open(sample_open), .approx_out(approx_out),
        .port_c_ref(port_c_ref), .extra_mv(extra_mv), .bad_dac(bad_dac),
        .port_a_in(port_a_in), .cmp_above(cmp_above), .dac_code(dac_code)
    );

    // any dac step in the first routine marks calibration
    always @(posedge clk)
        if (!rst && load_index == 2'd0 && fix.dac_step)
            saw_cal <= 1'b1;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task stop_test;
        if (fails == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : stop_test
    task check(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_tests++;
        if (got !== exp) begin
            $display("unexpected %0t %s", $time, m);
            fails++;
        end
    endtask : check
    task lim(input logic busy);
        if (busy) begin
            $display("unexpected %0t wait ran out", $time);
            fails++;
            stop_test();
        end
    endtask : lim
    function automatic logic [7:0] exp_code(input int vin, input int vr);
        int k;
        k = (vin * 512 + vr) / (2 * vr);
        return (k > 255) ? 8'hff : k[7:0];
    endfunction : exp_code
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge clk);
            if (pready === 1'b1)
                break;
        end
        lim(pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task do_reset(input logic irq, input logic [5:4] sw);
        @(posedge clk);
        rst <= 1'b1;
        irq_pin <= irq;
        port_c_sw <= sw;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
    endtask : do_reset

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        do_reset(1'b1, 2'b11);
        // user boot: restart, flag, result; full scale first
        for (int k = 0; k < 6; k++) begin
            q = $random(seed);
            extra_mv <= (k == 0) ? 13'd5150 : q[12:0] % 13'd5100;
            apb(1'b1, `ADCST_OFS_CTRL, 32'h0);
            apb(1'b0, `ADCST_OFS_CTRL, 32'h0);
            check(32'(q[7]), 32'h0, "flag survived restart");
            for (i = 0; i < 20 && q[7] !== 1'b1; i++)
                apb(1'b0, `ADCST_OFS_CTRL, 32'h0);
            lim(q[7] !== 1'b1);
            apb(1'b1, `ADCST_OFS_RESULT, 32'h0000_00a5);
            apb(1'b0, `ADCST_OFS_RESULT, 32'h0);
            exp_v = exp_code(int'(dac_code) * 5 / 4 + int'(extra_mv), 5160);
            check(32'(q[7:0]), 32'(exp_v), "result");
            check(32'(e), 32'h0, "error on mapped read");
        end
        apb(1'b0, 12'h020, 32'h0);
        check(q, 32'h0, "unmapped data");
        check(32'(e), 32'h1, "unmapped error");
        // loader, calibration, trim, ramp to pass
        extra_mv <= 13'h0000;
        do_reset(1'b0, 2'b00);
        q = 32'h0;
        for (i = 0; i < 400 && q[11:8] !== ADCST_CAL; i++)
            apb(1'b0, `ADCST_OFS_STATUS, 32'h0);
        lim(q[11:8] !== ADCST_CAL);
        check(32'(q[13:12]), 32'h0, "first load");
        check(32'(u_fix.addr_cnt), 32'(`ADCST_LOAD_END), "address steps");
        apb(1'b0, `ADCST_OFS_BOOTDATA, 32'h0);
        check(q, 32'((`ADCST_LOAD_END - 8'h01) ^ 8'h3c), "last byte");
        @(posedge clk);
        port_c_sw <= 2'b01;
        for (i = 0; i < 20000 && dac_code !== `ADCST_DAC_CAL_CODE; i++)
            @(negedge clk);
        lim(dac_code !== 12'hff0);
        repeat (200) @(negedge clk);
        check(32'(dac_code), 32'hff0, "dac not held");
        check(32'(load_index), 32'h0, "calibration left early");
        check(32'(saw_cal), 32'h1, "calibration not run");
        @(posedge clk);
        port_c_sw <= 2'b11;
        for (i = 0; i < 30000 && load_index !== 2'd2; i++)
            @(negedge clk);
        lim(load_index !== 2'd2);
        check(32'(port_c_ref), 32'h4, "reference trim");
        for (i = 0; i < 60000 && fix.pass_n !== 1'b0 && fix.fail_n !== 1'b0; i++)
            @(negedge clk);
        lim(fix.pass_n !== 1'b0);
        check(32'(fix.fail_n), 32'h1, "fail with pass");
        // switches open: calibration skipped, one bad ramp step
        q = $random(seed);
        bad_dac <= {1'b0, q[6:0] | 7'h01, 4'h0};
        do_reset(1'b0, 2'b11);
        saw_cal = 1'b0;
        for (i = 0; i < 60000 && fix.fail_n !== 1'b0 && fix.pass_n !== 1'b0; i++)
            @(negedge clk);
        lim(fix.fail_n !== 1'b0);
        check(32'(fix.pass_n), 32'h1, "pass after bad step");
        check(32'(saw_cal), 32'h0, "calibration not skipped");
        repeat (100) @(negedge clk);
        check(32'(dac_code), 32'(bad_dac), "ramp went on");
        stop_test();
    end
endmodule : adc_self_test_sequencer_tb
